// File: logic/adc_attenuator.sv
// ADC-path digital attenuator in 3 dB steps
`timescale 1ns/1ns
`default_nettype none
module adc_attenuator
    import ec_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic load,
    input wire logic [3:0] steps,
    input wire logic signed [15:0] sampleIn,
    output logic signed [15:0] sampleOut
);

    // ************************************************************
    // Gain table, Q15, one entry per 3 dB step
    // ************************************************************
    logic [15:0] gain;
    always_comb begin
        unique case (steps)
            4'h0: gain = 16'h7FFF;
            4'h1: gain = 16'h5A9E;
            4'h2: gain = 16'h4027;
            4'h3: gain = 16'h2D6B;
            4'h4: gain = 16'h2027;
            4'h5: gain = 16'h16C3;
            4'h6: gain = 16'h101D;
            4'h7: gain = 16'h0B68;
            4'h8: gain = 16'h0814;
            4'h9: gain = 16'h05B8;
            4'hA: gain = 16'h040C;
            4'hB: gain = 16'h02DE;
            4'hC: gain = 16'h0207;
            4'hD: gain = 16'h0170;
            4'hE: gain = 16'h0104;
            4'hF: gain = 16'h00B8;
        endcase
    end

    // Zero steps passes the sample untouched, so no rounding loss
    wire logic signed [32:0] product = sampleIn * $signed({1'b0, gain});
    wire logic signed [15:0] scaled = product[30:15];
    wire logic signed [15:0] next_sampleOut = (steps == 4'h0) ? sampleIn : scaled;

    // Output register, updated once per sample
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sampleOut <= 16'sh0000;
        end else if (ce && load) begin
            sampleOut <= next_sampleOut;
        end
    end

endmodule // adc_attenuator
`default_nettype wire

// File: logic/ec_ctrl_pkg.sv
// Package: field layouts, reset values and constants of the canceller control registers
package ec_ctrl_pkg;

    // ************************************************************
    // Register selection and widths
    // ************************************************************
    localparam int CTRL_WIDTH = 12;
    localparam int SAMPLE_WIDTH = 16;
    localparam logic [0:0] SEL_CANCELLER_TEST = 1'h0;
    localparam logic [0:0] SEL_CODEC_POWER_GAIN = 1'h1;
    localparam logic [11:0] CANCELLER_TEST_RESET = 12'h000;
    localparam logic [11:0] CODEC_POWER_GAIN_RESET = 12'h000;
    // Writable bits; reserved test bits are held at zero
    localparam logic [11:0] CANCELLER_TEST_WRITABLE = 12'hCCF;
    localparam logic [11:0] CODEC_POWER_GAIN_WRITABLE = 12'hE0F;

    // ************************************************************
    // Tuning register fields used here
    // ************************************************************
    localparam int NETWORK_CANCELLER_OFF_BIT = 8;
    localparam int GRADED_BETA_MSB = 3;
    localparam int GRADED_BETA_LSB = 2;

    // ************************************************************
    // Canceller tap budget and graded-beta tap counts
    // ************************************************************
    localparam int TAP_WIDTH = 10;
    localparam logic [9:0] TOTAL_TAPS = 10'h200;
    localparam logic [9:0] ACOUSTIC_SPLIT_TAPS = 10'h100;
    localparam logic [9:0] GRADE_TAPS_00 = 10'h200;
    localparam logic [9:0] GRADE_TAPS_01 = 10'h040;
    localparam logic [9:0] GRADE_TAPS_10 = 10'h080;
    localparam logic [9:0] GRADE_TAPS_11 = 10'h100;
    localparam logic [1:0] GRADE_DEFAULT_CODE = 2'h2;

    // First control register layout, bit 11 down to bit 0
    typedef struct packed {
        logic converterBypass;
        logic gainControlOff;
        logic [1:0] reservedHigh;
        logic analogLoopback;
        logic converterInputGround;
        logic [1:0] reservedLow;
        logic networkCoeffClear;
        logic halfDuplexOff;
        logic suppressionOff;
        logic acousticCoeffClear;
    } canceller_test_t;

    // Second control register layout, bit 11 down to bit 0
    typedef struct packed {
        logic codecPowerdown;
        logic speakerDriverPowerdown;
        logic micPreampBypass;
        logic [4:0] reserved;
        logic [3:0] inputAttenuation;
    } codec_power_gain_t;

    // Host write carrier from the serial control channel
    typedef struct packed {
        logic wrEn;
        logic [0:0] sel;
        logic [11:0] data;
    } host_write_t;

endpackage

// File: logic/echo_canceller_control_regs.sv
// Canceller control registers and the per-sample controls they drive
`timescale 1ns/1ns
`default_nettype none
// Function
// RQ1 - Codec bypass routes processor around codec
// RQ2 - Gain-control off disables receive AGC
// RQ3 - Analog loopback feeds ADC output to DAC
// RQ4 - Input ground forces ADC input to zero; analog loopback still sends ungrounded adcRaw to the DAC
// RQ5 - Network coefficient clear empties network filter
// RQ6 - Half-duplex off blocks half-duplex convergence mode
// RQ7 - Suppression off stops supplementary transmit suppression
// RQ8 - Acoustic coefficient clear empties acoustic filter
// RQ9 - Reset clears both control registers
// RQ10 - Processor reads registers every sample period
// RQ11 - Codec powerdown turns off whole codec
// RQ12 - Speaker powerdown turns off only driver
// RQ13 - Mic preamp bypass skips 26 dB stage
// RQ14 - ADC attenuation is 3 dB per step
// RQ15 - Network canceller off gives acoustic all taps
// RQ16 - Train on live speech, never generate
// RQ17 - Default decay grading assumes 0.38 dB/ms
// RQ18 - Tuning bits 3:2 select decay grading
// RQ19 - Register writes only in 16-bit mode
// RQ20 - Host writes zero to reserved bits
// RQ21 - New value applies from next sample period
module echo_canceller_control_regs
    import ec_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sampleTick,
    input wire logic serialMode16,
    input wire host_write_t hostWrite,
    input wire logic [0:0] hostRdSel,
    output logic [11:0] hostRdData,
    output logic [11:0] activeCancellerTest,
    output logic [11:0] activeCodecPowerGain,
    input wire logic [11:0] cancellerTuning,
    input wire logic signed [15:0] adcRaw,
    input wire logic signed [15:0] serialSample,
    input wire logic signed [15:0] cpuDacSample,
    output logic signed [15:0] cpuAdcSample,
    output logic signed [15:0] dacOut,
    output logic converterBypass,
    output logic gainControlOff,
    output logic analogLoopback,
    output logic converterInputGround,
    output logic networkCoeffClear,
    output logic halfDuplexOff,
    output logic suppressionOff,
    output logic acousticCoeffClear,
    output logic codecPowerdown,
    output logic speakerDriverPowerdown,
    output logic micPreampBypass,
    output logic [3:0] inputAttenuation,
    output logic [9:0] acousticTaps,
    output logic [9:0] networkTaps,
    output logic [9:0] gradedBetaTaps
);

    // ************************************************************
    // Host write decode
    // ************************************************************
    logic [11:0] shadowTest;
    logic [11:0] shadowPower;
    logic pendingTest;
    logic pendingPower;

    // Writes outside 16-bit mode are dropped silently
    wire logic writeOk = hostWrite.wrEn && serialMode16; // [RQ19]
    wire logic writeTest = writeOk && (hostWrite.sel == SEL_CANCELLER_TEST);
    wire logic writePower = writeOk && (hostWrite.sel == SEL_CODEC_POWER_GAIN);
    // Reserved bits are masked so a stray one cannot reach test logic
    wire logic [11:0] maskedTest = hostWrite.data & CANCELLER_TEST_WRITABLE; // [RQ20]
    wire logic [11:0] maskedPower = hostWrite.data & CODEC_POWER_GAIN_WRITABLE; // [RQ20]

    // ************************************************************
    // Shadow copies written by the host
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shadowTest <= CANCELLER_TEST_RESET; // [RQ9]
            shadowPower <= CODEC_POWER_GAIN_RESET; // [RQ9]
        end else if (ce) begin
            if (writeTest) begin
                shadowTest <= maskedTest;
            end
            if (writePower) begin
                shadowPower <= maskedPower;
            end
        end
    end

    // Pending flags: a write in the tick cycle wins over the clear
    wire logic next_pendingTest = writeTest || (pendingTest && !sampleTick);
    wire logic next_pendingPower = writePower || (pendingPower && !sampleTick);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pendingTest <= 1'b0;
            pendingPower <= 1'b0;
        end else if (ce) begin
            pendingTest <= next_pendingTest;
            pendingPower <= next_pendingPower;
        end
    end

    // ************************************************************
    // Active copies, taken over only at a sample boundary
    // ************************************************************
    // Holding changes to the tick keeps one sample from seeing mixed settings
    always_ff @(posedge core_clk) begin
        if (rst) begin
            activeCancellerTest <= CANCELLER_TEST_RESET; // [RQ9]
            activeCodecPowerGain <= CODEC_POWER_GAIN_RESET; // [RQ9]
        end else if (ce && sampleTick) begin
            if (pendingTest) begin
                activeCancellerTest <= shadowTest; // [RQ10] [RQ21]
            end
            if (pendingPower) begin
                activeCodecPowerGain <= shadowPower; // [RQ10] [RQ21]
            end
        end
    end

    // Host readback shows what was last written
    wire logic [11:0] next_hostRdData = (hostRdSel == SEL_CANCELLER_TEST) ? shadowTest : shadowPower;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hostRdData <= CANCELLER_TEST_RESET;
        end else if (ce) begin
            hostRdData <= next_hostRdData;
        end
    end

    // ************************************************************
    // Field views of the active registers
    // ************************************************************
    canceller_test_t testView;
    codec_power_gain_t powerView;
    assign testView = canceller_test_t'(activeCancellerTest);
    assign powerView = codec_power_gain_t'(activeCodecPowerGain);

    assign converterBypass = testView.converterBypass; // [RQ1]
    assign gainControlOff = testView.gainControlOff; // [RQ2]
    assign analogLoopback = testView.analogLoopback; // [RQ3]
    assign converterInputGround = testView.converterInputGround; // [RQ4]
    assign networkCoeffClear = testView.networkCoeffClear; // [RQ5]
    assign halfDuplexOff = testView.halfDuplexOff; // [RQ6]
    assign suppressionOff = testView.suppressionOff; // [RQ7]
    assign acousticCoeffClear = testView.acousticCoeffClear; // [RQ8]
    assign codecPowerdown = powerView.codecPowerdown; // [RQ11]
    // Speaker driver alone; the rest of the codec keeps running
    assign speakerDriverPowerdown = powerView.speakerDriverPowerdown && !powerView.codecPowerdown; // [RQ12]
    assign micPreampBypass = powerView.micPreampBypass; // [RQ13]
    assign inputAttenuation = powerView.inputAttenuation; // [RQ14]

    // ************************************************************
    // Transmit sample path into the processor
    // ************************************************************
    // Bypass takes the serial test sample, grounding zeroes the ADC input
    wire logic signed [15:0] groundedAdc = converterInputGround ? 16'sh0000 : adcRaw; // [RQ4]
    wire logic signed [15:0] codecAdc = codecPowerdown ? 16'sh0000 : groundedAdc; // [RQ11]
    wire logic signed [15:0] pathSample = converterBypass ? serialSample : codecAdc; // [RQ1]

    adc_attenuator attenuator (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .load(sampleTick),
        .steps(inputAttenuation), // [RQ14]
        .sampleIn(pathSample),
        .sampleOut(cpuAdcSample)
    );

    // ************************************************************
    // Receive sample path to the DAC
    // ************************************************************
    // Only processor output or looped ADC data ever reaches the DAC
    wire logic signed [15:0] loopSample = analogLoopback ? adcRaw : cpuDacSample; // [RQ3] [RQ16]
    wire logic dacSilent = codecPowerdown || speakerDriverPowerdown || converterBypass; // [RQ12]
    wire logic signed [15:0] next_dacOut = dacSilent ? 16'sh0000 : loopSample;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dacOut <= 16'sh0000;
        end else if (ce && sampleTick) begin
            dacOut <= next_dacOut;
        end
    end

    // ************************************************************
    // Tap allocation and graded-beta decode
    // ************************************************************
    wire logic networkOff = cancellerTuning[NETWORK_CANCELLER_OFF_BIT];
    wire logic [1:0] gradeCode = cancellerTuning[GRADED_BETA_MSB:GRADED_BETA_LSB]; // [RQ18]
    // Full budget to the acoustic side when the network side is off
    wire logic [9:0] next_acousticTaps = networkOff ? TOTAL_TAPS : ACOUSTIC_SPLIT_TAPS; // [RQ15]
    wire logic [9:0] next_networkTaps = networkOff ? 10'h000 : (TOTAL_TAPS - ACOUSTIC_SPLIT_TAPS);
    logic [9:0] next_gradedBetaTaps;
    always_comb begin
        unique case (gradeCode)
            2'h0: next_gradedBetaTaps = GRADE_TAPS_00;
            2'h1: next_gradedBetaTaps = GRADE_TAPS_01;
            2'h2: next_gradedBetaTaps = GRADE_TAPS_10; // [RQ17]
            2'h3: next_gradedBetaTaps = GRADE_TAPS_11;
        endcase
    end

    // Allocation follows the tuning word at each sample boundary
    always_ff @(posedge core_clk) begin
        if (rst) begin
            acousticTaps <= ACOUSTIC_SPLIT_TAPS;
            networkTaps <= TOTAL_TAPS - ACOUSTIC_SPLIT_TAPS;
            gradedBetaTaps <= GRADE_TAPS_10; // [RQ17]
        end else if (ce && sampleTick) begin
            acousticTaps <= next_acousticTaps; // [RQ15]
            networkTaps <= next_networkTaps;
            gradedBetaTaps <= next_gradedBetaTaps; // [RQ18]
        end
    end

endmodule // echo_canceller_control_regs
`default_nettype wire

// File: sim/echo_canceller_control_regs_props.sv
// Concurrent checks on the canceller control register ports
`timescale 1ns/1ns
`default_nettype none
module echo_canceller_control_regs_props
    import ec_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sampleTick,
    input wire logic serialMode16,
    input wire host_write_t hostWrite,
    input wire logic [0:0] hostRdSel,
    input wire logic [11:0] hostRdData,
    input wire logic [11:0] activeCancellerTest,
    input wire logic [11:0] activeCodecPowerGain,
    input wire logic [11:0] cancellerTuning,
    input wire logic signed [15:0] adcRaw,
    input wire logic signed [15:0] serialSample,
    input wire logic signed [15:0] cpuAdcSample,
    input wire logic signed [15:0] dacOut,
    input wire logic speakerDriverPowerdown,
    input wire logic [9:0] acousticTaps,
    input wire logic [9:0] networkTaps,
    input wire logic [9:0] gradedBetaTaps
);
    // ************************************************************
    // Helper terms
    // ************************************************************
    wire logic wrTaken = ce && hostWrite.wrEn && serialMode16;
    wire logic tick = ce && sampleTick;
    wire logic [1:0] gradeCode = cancellerTuning[3:2];
    wire logic silence = activeCodecPowerGain[11] | activeCodecPowerGain[10]
        | activeCancellerTest[11];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Grade code to tap count
    function automatic logic [9:0] gradeTaps(input logic [1:0] g);
        return (g == 2'h0) ? 10'h200 : (g == 2'h1) ? 10'h040 : (g == 2'h2) ? 10'h080 : 10'h100;
    endfunction

    reset_clear_a: assert property (
        $past(rst) |-> activeCancellerTest == 12'h000 && activeCodecPowerGain == 12'h000
        && gradedBetaTaps == 10'h080) else $error("Reset values wrong");
    hold_between_ticks_a: assert property (
        !tick |=> $stable(activeCancellerTest) && $stable(activeCodecPowerGain))
        else $error("Active register moved without a tick");
    write_applied_a: assert property (
        wrTaken && hostWrite.sel == SEL_CANCELLER_TEST ##1 tick |=> activeCancellerTest
        == ($past(hostWrite.data, 2) & CANCELLER_TEST_WRITABLE)) else $error("Write not applied");
    refused_write_a: assert property (
        $past(ce) && !$past(rst) && !$past(wrTaken) && $stable(hostRdSel) |=> $stable(hostRdData))
        else $error("Shadow changed without a taken write");
    speaker_only_a: assert property (
        speakerDriverPowerdown == (activeCodecPowerGain[10] && !activeCodecPowerGain[11]))
        else $error("Speaker powerdown wrong");
    dac_silent_a: assert property (
        tick && silence |=> dacOut == 16'h0000) else $error("DAC not silenced");
    loopback_path_a: assert property (
        tick && !silence && activeCancellerTest[7] |=> dacOut == $past(adcRaw))
        else $error("Loopback sample wrong");
    ground_input_a: assert property (
        tick && activeCancellerTest[6] && !activeCancellerTest[11] |=> cpuAdcSample == 16'h0000)
        else $error("Grounded input not zero");
    bypass_input_a: assert property (
        tick && activeCancellerTest[11] && activeCodecPowerGain[3:0] == 4'h0
        |=> cpuAdcSample == $past(serialSample)) else $error("Bypass sample wrong");
    split_taps_a: assert property (
        tick && cancellerTuning[8] |=> acousticTaps == 10'h200 && networkTaps == 10'h000)
        else $error("Tap split wrong");
    grade_taps_a: assert property (
        tick |=> gradedBetaTaps == gradeTaps($past(gradeCode))) else $error("Grade taps wrong");
endmodule // echo_canceller_control_regs_props
bind echo_canceller_control_regs echo_canceller_control_regs_props props (.core_clk, .rst, .ce,
    .sampleTick, .serialMode16, .hostWrite, .hostRdSel, .hostRdData, .activeCancellerTest,
    .activeCodecPowerGain, .cancellerTuning, .adcRaw, .serialSample, .cpuAdcSample, .dacOut,
    .speakerDriverPowerdown, .acousticTaps, .networkTaps, .gradedBetaTaps);
`default_nettype wire

// File: sim/echo_canceller_control_regs_tb.sv
// Self-checking bench for the canceller control registers
`timescale 1ns/1ns
`default_nettype none
module echo_canceller_control_regs_tb;
    import ec_ctrl_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, sampleTick = 1'b0, req = 1'b0, mode = 1'b1;
    logic keepRes = 1'b0, serialMode16;
    logic [0:0] reqSel = 1'h0, hostRdSel = 1'h0, s;
    logic [11:0] reqData = 12'h000, cancellerTuning = 12'h000, expT, expC, d, hostRdData;
    logic [11:0] activeCancellerTest, activeCodecPowerGain;
    logic signed [15:0] adcRaw = 16'h0000, serialSample = 16'h0000, cpuDacSample = 16'h0000;
    logic signed [15:0] cpuAdcSample, dacOut;
    logic [7:0] firstBits;
    logic [6:0] codecBits;
    logic [9:0] acousticTaps, networkTaps, gradedBetaTaps;
    logic [31:0] seed = 32'h0FDD, r;
    host_write_t hostWrite;
    int errors = 0, compares = 0;
    always #5 core_clk = ~core_clk;

    host_ctrl_model HOST (.req, .reqSel, .reqData, .mode, .keepRes, .hostWrite, .serialMode16);
    echo_canceller_control_regs DUT (.core_clk, .rst, .ce, .sampleTick, .serialMode16,
        .hostWrite, .hostRdSel, .hostRdData, .activeCancellerTest, .activeCodecPowerGain,
        .cancellerTuning, .adcRaw, .serialSample, .cpuDacSample, .cpuAdcSample, .dacOut,
        .converterBypass(firstBits[7]), .gainControlOff(firstBits[6]),
        .analogLoopback(firstBits[5]), .converterInputGround(firstBits[4]),
        .networkCoeffClear(firstBits[3]), .halfDuplexOff(firstBits[2]),
        .suppressionOff(firstBits[1]), .acousticCoeffClear(firstBits[0]),
        .codecPowerdown(codecBits[6]), .speakerDriverPowerdown(codecBits[5]),
        .micPreampBypass(codecBits[4]), .inputAttenuation(codecBits[3:0]),
        .acousticTaps, .networkTaps, .gradedBetaTaps);

    // ************************************************************
    // Bench helpers
    // ************************************************************
    function automatic logic [31:0] rng();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [9:0] gradeExp(input logic [1:0] g);
        return (g == 2'h0) ? 10'h200 : (g == 2'h1) ? 10'h040 : (g == 2'h2) ? 10'h080 : 10'h100;
    endfunction
    // Outputs expected one tick after the new settings took hold
    function automatic logic [15:0] dacExp();
        return (expC[11] | expC[10] | expT[11]) ? 16'h0000 : expT[7] ? adcRaw : cpuDacSample;
    endfunction
    function automatic logic [15:0] adcExp();
        return expT[11] ? serialSample : (expC[11] | expT[6]) ? 16'h0000 : adcRaw;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Attenuated sample: 3 dB per step below the unscaled path value
    function automatic real attExp(input logic [15:0] base, input logic [3:0] n);
        return $itor($signed(base)) * 10.0 ** (-0.15 * n);
    endfunction
    // Table gains are rounded and the product truncated, so allow two LSBs
    task automatic chkNear(input logic signed [15:0] got, input real exp);
        compares++;
        if ($isunknown(got) || got > exp + 2.0 || got < exp - 2.0) begin
            errors++;
            $display("Error at %0t: got %0d expected about %0f", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("Totals: %0d errors in %0d compares", errors, compares);
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One write edge; only writes in 16-bit mode with ce high count
    task automatic put(input logic [0:0] ws, input logic [11:0] wd, input logic m, input logic e);
        req = 1'b1;
        reqSel = ws;
        reqData = wd;
        mode = m;
        ce = e;
        @(posedge core_clk);
        #1;
        if (m && e && ws == SEL_CANCELLER_TEST) expT = wd & CANCELLER_TEST_WRITABLE;
        if (m && e && ws == SEL_CODEC_POWER_GAIN) expC = wd & CODEC_POWER_GAIN_WRITABLE;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge core_clk);
        #1;
        rst = 1'b0;
        expT = 12'h000;
        expC = 12'h000;
        chk(activeCancellerTest, 12'h000);
        chk(activeCodecPowerGain, 12'h000);
        chk(gradedBetaTaps, 10'h080);
        for (int i = 0; i < 60; i++) begin
            r = rng();
            adcRaw = r[15:0];
            serialSample = r[31:16];
            r = rng();
            cpuDacSample = r[15:0];
            cancellerTuning = r[27:16];
            hostRdSel = r[28];
            keepRes = r[29];
            r = rng();
            // First two rounds put all ones into each register
            s = (i < 2) ? i[0] : r[12];
            d = (i < 2) ? 12'hFFF : r[11:0];
            put(s, d, i < 2 || r[14:13] != 2'h0, i < 2 || r[17:15] != 3'h0);
            r = rng();
            put(r[12], r[11:0] & {8'hFF, {4{r[18]}}}, r[14:13] != 2'h0, 1'b1);
            req = 1'b0;
            ce = 1'b1;
            // Two ticks: the first applies, the second uses the new settings
            sampleTick = 1'b1;
            repeat (2) @(posedge core_clk);
            #1;
            sampleTick = 1'b0;
            chk(activeCancellerTest, expT);
            chk(activeCodecPowerGain, expC);
            chk(hostRdData, (hostRdSel == 1'h0) ? expT : expC);
            chk(firstBits[7:4], {expT[11:10], expT[7:6]});
            chk(firstBits[3:0], expT[3:0]);
            chk(codecBits[6:4], {expC[11], expC[10] & ~expC[11], expC[9]});
            chk(codecBits[3:0], expC[3:0]);
            chk(acousticTaps, cancellerTuning[8] ? 10'h200 : 10'h100);
            chk(networkTaps, cancellerTuning[8] ? 10'h000 : 10'h100);
            chk(gradedBetaTaps, gradeExp(cancellerTuning[3:2]));
            chk(dacOut, dacExp());
            if (expC[3:0] == 4'h0) chk(cpuAdcSample, adcExp());
            else chkNear(cpuAdcSample, attExp(adcExp(), expC[3:0]));
        end
        // Reset again after the last round with settings held
        rst = 1'b1;
        @(posedge core_clk);
        #1;
        rst = 1'b0;
        chk(activeCancellerTest, 12'h000);
        chk(activeCodecPowerGain, 12'h000);
        test_done();
    end

    // Watchdog so a stuck run still reaches the verdict
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        test_done();
    end
endmodule // echo_canceller_control_regs_tb
`default_nettype wire

// File: sim/host_ctrl_model.sv
// Host model driving register writes over the serial control channel
`timescale 1ns/1ns
`default_nettype none
module host_ctrl_model
    import ec_ctrl_pkg::*;
(
    input wire logic req,
    input wire logic [0:0] reqSel,
    input wire logic [11:0] reqData,
    input wire logic mode,
    input wire logic keepRes,
    output host_write_t hostWrite,
    output logic serialMode16
);
    // ************************************************************
    // Write word assembly
    // ************************************************************
    // Reserved test bits go out as zero unless a refusal case keeps them
    wire logic [11:0] cleanMask = (reqSel == SEL_CANCELLER_TEST) ? CANCELLER_TEST_WRITABLE
        : CODEC_POWER_GAIN_WRITABLE;
    wire logic [11:0] wordOut = keepRes ? reqData : (reqData & cleanMask);
    // Idle data lines carry the inverse, so a stale word never looks live
    assign hostWrite = {req, reqSel, req ? wordOut : ~reqData};
    assign serialMode16 = mode;
endmodule // host_ctrl_model
`default_nettype wire
